// ---- fcr_defs.svh ----
// constants of the fault flag and mask register block
`ifndef FCR_DEFS_SVH
`define FCR_DEFS_SVH

// ---------------------------------------------------------------
// serial slave
// ---------------------------------------------------------------
`define FCR_SLAVE_ADDR 7'h6A
`define FCR_BITS_PER_BYTE 4'h8

// ---------------------------------------------------------------
// register offsets and answers
// ---------------------------------------------------------------
`define FCR_OFS_FAULT 8'h01
`define FCR_OFS_TEMP 8'h02
`define FCR_UNMAPPED_DATA 8'hFF

// ---------------------------------------------------------------
// fault register fields
// ---------------------------------------------------------------
`define FCR_FLT_OV_BIT 7
`define FCR_FLT_UV_BIT 6
`define FCR_FLT_UVLO_BIT 5
`define FCR_FLT_OCP_BIT 4
`define FCR_FLT_MASK_RST 4'h0

// ---------------------------------------------------------------
// temperature control register fields
// ---------------------------------------------------------------
`define FCR_TMP_TSEN_BIT 7
`define FCR_TMP_CODE_HI 6
`define FCR_TMP_CODE_LO 5
`define FCR_TMP_ENINT_BIT 3
`define FCR_TMP_WAKEM_BIT 2
`define FCR_TMP_RSTM_BIT 1
`define FCR_TMP_TIMERM_BIT 0
`define FCR_TMP_TSEN_RST 1'h1
`define FCR_TMP_ENINT_RST 1'h1
`define FCR_TMP_MASK_RST 3'h0
`define FCR_TMP_RESERVED 1'h0

`endif

// ---- fcr_pkg.sv ----
// types shared by the fault flag and mask register block
package fcr_pkg;

   // ---------------------------------------------------------------
   // serial slave states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      FCR_ST_IDLE = 4'h0,
      FCR_ST_ADDR = 4'h1,
      FCR_ST_ADDR_ACK = 4'h2,
      FCR_ST_PTR = 4'h3,
      FCR_ST_PTR_ACK = 4'h4,
      FCR_ST_WDATA = 4'h5,
      FCR_ST_WDATA_ACK = 4'h6,
      FCR_ST_RDATA = 4'h7,
      FCR_ST_RACK = 4'h8
   } fcr_state_t;

   // thermistor fault codes
   typedef enum logic [1:0] {
      FCR_TS_NORMAL = 2'h0,
      FCR_TS_COLD_HOT = 2'h1,
      FCR_TS_COOL = 2'h2,
      FCR_TS_WARM = 2'h3
   } fcr_ts_code_t;

endpackage

// ---- fcr_reg_if.sv ----
// register access path between the serial slave and the register file
interface fcr_reg_if;
   logic wr_stb;
   logic rd_stb;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport master (
      output wr_stb,
      output rd_stb,
      output addr,
      output wdata,
      input rdata
   );

   modport slave (
      input wr_stb,
      input rd_stb,
      input addr,
      input wdata,
      output rdata
   );
endinterface

// ---- fcr_regs.sv ----
// fault flags, masks, temperature control and interrupt pin
`include "fcr_defs.svh"

module fcr_regs
   import fcr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // register access
   fcr_reg_if.slave bus,
   // fault detectors
   input wire logic input_overvoltage_det,
   input wire logic input_below_sleep,
   input wire logic battery_low_lockout_det,
   input wire logic battery_overcurrent_evt,
   input wire fcr_ts_code_t thermistor_fault_code_in,
   // other interrupt sources, levels held by their owners
   input wire logic pushbutton_wake_pend,
   input wire logic pushbutton_reset_pend,
   input wire logic safety_timer_fault,
   input wire logic charge_status_pend,
   // outputs
   output logic int_b,
   output logic thermistor_sense_enable
);

   logic ov_q, uv_q, uvlo_q, ocp_q, uv_prev_q;
   logic [3:0] fmask_q;
   logic sense_en_q, en_int_q, wake_m_q, rst_m_q, timer_m_q;
   fcr_ts_code_t code_q;
   logic int_b_q;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   wire sel_fault = (bus.addr == `FCR_OFS_FAULT);
   wire sel_temp = (bus.addr == `FCR_OFS_TEMP);
   wire rd_fault = bus.rd_stb && sel_fault;
   wire wr_fault = bus.wr_stb && sel_fault;
   wire wr_temp = bus.wr_stb && sel_temp;
   wire uv_rise = input_below_sleep && !uv_prev_q;
   wire [3:0] flags = {ov_q, uv_q, uvlo_q, ocp_q};
   wire [7:0] fault_word = {flags, fmask_q};
   wire [7:0] temp_word = {sense_en_q, code_q, `FCR_TMP_RESERVED, en_int_q, wake_m_q,
                           rst_m_q, timer_m_q};
   // unmapped offsets answer all ones
   assign bus.rdata = sel_fault ? fault_word : (sel_temp ? temp_word : `FCR_UNMAPPED_DATA);

   // a detector that is still active, or for undervoltage a new rise, wins over the clear by a read
   wire ov_d = input_overvoltage_det || (ov_q && !rd_fault);
   wire uv_d = uv_rise || (uv_q && !rd_fault);
   wire uvlo_d = battery_low_lockout_det || (uvlo_q && !rd_fault);
   wire ocp_d = battery_overcurrent_evt || (ocp_q && !rd_fault);

   // masked faults still show in their flags, only the pin is gated
   wire fault_int = |(flags & ~fmask_q);
   wire misc_int = (pushbutton_wake_pend && !wake_m_q)
      || (pushbutton_reset_pend && !rst_m_q)
      || (safety_timer_fault && !timer_m_q)
      || (charge_status_pend && en_int_q);
   wire int_b_d = !(fault_int || misc_int);

   // ---------------------------------------------------------------
   // flags
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         {ov_q, uv_q, uvlo_q, ocp_q, uv_prev_q} <= 5'h00;
      end else begin
         {ov_q, uv_q, uvlo_q, ocp_q} <= {ov_d, uv_d, uvlo_d, ocp_d};
         uv_prev_q <= input_below_sleep;
      end
   end

   // ---------------------------------------------------------------
   // software fields
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         fmask_q <= `FCR_FLT_MASK_RST;
      end else if (wr_fault) begin
         fmask_q <= bus.wdata[3:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sense_en_q <= `FCR_TMP_TSEN_RST;
         en_int_q <= `FCR_TMP_ENINT_RST;
         {wake_m_q, rst_m_q, timer_m_q} <= `FCR_TMP_MASK_RST;
      end else if (wr_temp) begin
         sense_en_q <= bus.wdata[`FCR_TMP_TSEN_BIT];
         en_int_q <= bus.wdata[`FCR_TMP_ENINT_BIT];
         wake_m_q <= bus.wdata[`FCR_TMP_WAKEM_BIT];
         rst_m_q <= bus.wdata[`FCR_TMP_RSTM_BIT];
         timer_m_q <= bus.wdata[`FCR_TMP_TIMERM_BIT];
      end
   end

   // code is sampled so a read sees one stable value
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         code_q <= FCR_TS_NORMAL;
         int_b_q <= 1'b1;
      end else begin
         code_q <= thermistor_fault_code_in;
         int_b_q <= int_b_d;
      end
   end

   assign int_b = int_b_q;
   assign thermistor_sense_enable = sense_en_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_OV_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
      rd_fault && input_overvoltage_det |=> ov_q)
      else $error("overvoltage flag cleared while fault present");
   AST_UV_ONCE: assert property (@(posedge clock) disable iff (!rst_b)
      rd_fault && !uv_rise |=> !uv_q ##1 (!uv_q || $past(uv_rise)))
      else $error("undervoltage flag not cleared once by a read");
   AST_UVLO_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
      battery_low_lockout_det |=> uvlo_q && bus.rdata[`FCR_FLT_UVLO_BIT] || !sel_fault)
      else $error("lockout flag lost while condition present");
   AST_OCP_CLEAR: assert property (@(posedge clock) disable iff (!rst_b)
      rd_fault && !battery_overcurrent_evt |=> !ocp_q)
      else $error("overcurrent flag survived a read");
   AST_RESET_VALUES: assert property (@(posedge clock)
      !rst_b |=> fmask_q == 4'h0 && sense_en_q && en_int_q && !wake_m_q && !rst_m_q && !timer_m_q)
      else $error("wrong reset value");
   AST_TS_WRITE: assert property (@(posedge clock) disable iff (!rst_b)
      wr_temp |=> thermistor_sense_enable == $past(bus.wdata[7]))
      else $error("thermistor enable not written");
   AST_CODE_READ: assert property (@(posedge clock) disable iff (!rst_b)
      sel_temp ##1 sel_temp |-> bus.rdata[6:5] == $past(thermistor_fault_code_in)
      && bus.rdata[4] == 1'b0)
      else $error("temperature code or reserved bit wrong");
   AST_UNMAPPED: assert property (@(posedge clock) disable iff (!rst_b)
      !sel_fault && !sel_temp |-> bus.rdata == 8'hFF)
      else $error("unmapped read not all ones");
   AST_INT_FAULT: assert property (@(posedge clock) disable iff (!rst_b)
      (|(flags & ~fmask_q)) |=> !int_b)
      else $error("unmasked fault did not assert the pin");
   AST_INT_QUIET: assert property (@(posedge clock) disable iff (!rst_b)
      !fault_int && !pushbutton_wake_pend && !pushbutton_reset_pend && !safety_timer_fault
      && charge_status_pend && !en_int_q |=> int_b)
      else $error("charge status reached the pin with the option off");
   AST_MASKS: assert property (@(posedge clock) disable iff (!rst_b)
      !fault_int && !pushbutton_wake_pend && !pushbutton_reset_pend && !charge_status_pend
      && safety_timer_fault && timer_m_q |=> int_b)
      else $error("masked timer fault reached the pin");

endmodule

// ---- fcr_top.sv ----
// fault flag and mask registers behind a two-wire serial slave
//
// Behaviour
// - overvoltage flag bit 7 persists while present
// - undervoltage flag bit 6 set once, read clears
// - lockout flag bit 5 persists while present
// - overcurrent flag bit 4 cleared by read
// - fault register 0x01, low masks reset zero
// - bit 7 enables thermistor sense, resets on
// - read-only two-bit thermistor fault code
// - option bit adds charge status, resets one
// - bit 2 masks pushbutton wake interrupt
// - bit 1 masks pushbutton reset interrupt only
// - bit 0 masks safety timer interrupt
// - register 0x02 resets 1xxx1000, bit 4 reserved
// - seven-bit slave at address 6A
// - undefined register reads return all ones
`include "fcr_defs.svh"

module fcr_top
   import fcr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // serial pins
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_b,
   // fault detectors
   input wire logic input_overvoltage_det,
   input wire logic input_below_sleep,
   input wire logic battery_low_lockout_det,
   input wire logic battery_overcurrent_evt,
   input wire fcr_ts_code_t thermistor_fault_code_in,
   // other interrupt sources
   input wire logic pushbutton_wake_pend,
   input wire logic pushbutton_reset_pend,
   input wire logic safety_timer_fault,
   input wire logic charge_status_pend,
   // outputs
   output logic int_b,
   output logic thermistor_sense_enable
);

   fcr_reg_if rif ();

   fcr_state_t state_q, state_d;
   logic scl_q, sda_q;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] tx_q, tx_d;
   logic [7:0] ptr_q, ptr_d;
   logic rw_q, rw_d;
   logic drive_q, drive_d;
   logic zero_q;
   logic oe_b_q;
   logic wr_stb, rd_stb;

   // ---------------------------------------------------------------
   // line events
   // ---------------------------------------------------------------
   // pins are synchronous; one stage of history gives the edges
   wire scl_rise = scl && !scl_q;
   wire scl_fall = !scl && scl_q;
   wire start_cond = scl && scl_q && sda_q && !sda_in;
   wire stop_cond = scl && scl_q && !sda_q && sda_in;
   wire byte_full = (cnt_q == `FCR_BITS_PER_BYTE);
   wire addr_hit = (shift_q[7:1] == `FCR_SLAVE_ADDR);
   wire [3:0] cnt_inc = cnt_q + 4'h1;
   wire [7:0] ptr_inc = ptr_q + 8'h01;
   wire master_ack = !sda_in;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      tx_d = tx_q;
      ptr_d = ptr_q;
      rw_d = rw_q;
      drive_d = drive_q;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      if (start_cond) begin
         // repeated start keeps the register pointer
         state_d = FCR_ST_ADDR;
         cnt_d = 4'h0;
         drive_d = 1'b0;
      end else if (stop_cond) begin
         state_d = FCR_ST_IDLE;
         drive_d = 1'b0;
      end else begin
         unique case (state_q)
            FCR_ST_IDLE: begin
               drive_d = 1'b0;
            end
            FCR_ST_ADDR, FCR_ST_PTR, FCR_ST_WDATA: begin
               if (scl_rise && !byte_full) begin
                  shift_d = {shift_q[6:0], sda_in};
                  cnt_d = cnt_inc;
               end else if (scl_fall && byte_full) begin
                  cnt_d = 4'h0;
                  if (state_q == FCR_ST_ADDR) begin
                     if (addr_hit) begin
                        rw_d = shift_q[0];
                        drive_d = 1'b1;
                        state_d = FCR_ST_ADDR_ACK;
                     end else begin
                        state_d = FCR_ST_IDLE;
                     end
                  end else if (state_q == FCR_ST_PTR) begin
                     ptr_d = shift_q;
                     drive_d = 1'b1;
                     state_d = FCR_ST_PTR_ACK;
                  end else begin
                     // writes to offsets this block does not hold are dropped
                     wr_stb = 1'b1;
                     ptr_d = ptr_inc;
                     drive_d = 1'b1;
                     state_d = FCR_ST_WDATA_ACK;
                  end
               end
            end
            FCR_ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (rw_q) begin
                     // the read strobe clears read-sensitive flags as the byte is taken
                     rd_stb = 1'b1;
                     tx_d = rif.rdata;
                     drive_d = !rif.rdata[7];
                     ptr_d = ptr_inc;
                     state_d = FCR_ST_RDATA;
                  end else begin
                     drive_d = 1'b0;
                     state_d = FCR_ST_PTR;
                  end
               end
            end
            FCR_ST_PTR_ACK: begin
               if (scl_fall) begin
                  drive_d = 1'b0;
                  state_d = FCR_ST_WDATA;
               end
            end
            FCR_ST_WDATA_ACK: begin
               if (scl_fall) begin
                  drive_d = 1'b0;
                  state_d = FCR_ST_WDATA;
               end
            end
            FCR_ST_RDATA: begin
               // bit 7 went out at the load; each of the next seven falls moves one bit on, the eighth releases the line
               if (scl_rise) begin
                  cnt_d = cnt_inc;
               end else if (scl_fall) begin
                  if (byte_full) begin
                     drive_d = 1'b0;
                     cnt_d = 4'h0;
                     state_d = FCR_ST_RACK;
                  end else begin
                     tx_d = {tx_q[6:0], 1'b0};
                     drive_d = !tx_q[6];
                  end
               end
            end
            FCR_ST_RACK: begin
               if (scl_rise) begin
                  // a not-acknowledge ends the read; wait for stop
                  if (!master_ack) begin
                     state_d = FCR_ST_IDLE;
                  end
               end else if (scl_fall) begin
                  rd_stb = 1'b1;
                  tx_d = rif.rdata;
                  drive_d = !rif.rdata[7];
                  ptr_d = ptr_inc;
                  state_d = FCR_ST_RDATA;
               end
            end
            default: begin
               state_d = FCR_ST_IDLE;
               drive_d = 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_q <= FCR_ST_IDLE;
         cnt_q <= 4'h0;
         shift_q <= 8'h00;
         tx_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         drive_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         tx_q <= tx_d;
         ptr_q <= ptr_d;
         rw_q <= rw_d;
         drive_q <= drive_d;
      end
   end

   // idle bus is high on both lines
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         zero_q <= 1'b0;
      end else begin
         scl_q <= scl;
         sda_q <= sda_in;
         zero_q <= 1'b0;
      end
   end

   // the enable has its own flop so no gate sits between register and pin;
   // it always holds the inverse of drive_q
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         oe_b_q <= 1'b1;
      end else begin
         oe_b_q <= !drive_d;
      end
   end

   // open drain: the pin only ever pulls low
   assign sda_out = zero_q;
   assign sda_oe_b = oe_b_q;

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   assign rif.wr_stb = wr_stb;
   assign rif.rd_stb = rd_stb;
   assign rif.addr = ptr_q;
   assign rif.wdata = shift_q;

   fcr_regs u_regs (
      .clock(clock),
      .rst_b(rst_b),
      .bus(rif.slave),
      .input_overvoltage_det(input_overvoltage_det),
      .input_below_sleep(input_below_sleep),
      .battery_low_lockout_det(battery_low_lockout_det),
      .battery_overcurrent_evt(battery_overcurrent_evt),
      .thermistor_fault_code_in(thermistor_fault_code_in),
      .pushbutton_wake_pend(pushbutton_wake_pend),
      .pushbutton_reset_pend(pushbutton_reset_pend),
      .safety_timer_fault(safety_timer_fault),
      .charge_status_pend(charge_status_pend),
      .int_b(int_b),
      .thermistor_sense_enable(thermistor_sense_enable)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_ADDR_ACK: assert property (@(posedge clock) disable iff (!rst_b)
      state_q == FCR_ST_ADDR && scl_fall && byte_full && addr_hit && !start_cond
      && !stop_cond |=> !sda_oe_b && state_q == FCR_ST_ADDR_ACK)
      else $error("own address not acknowledged");
   AST_ADDR_MISS: assert property (@(posedge clock) disable iff (!rst_b)
      state_q == FCR_ST_ADDR && scl_fall && byte_full && !addr_hit && !start_cond
      && !stop_cond |=> sda_oe_b && state_q == FCR_ST_IDLE)
      else $error("foreign address acknowledged");
   AST_RELEASE_STOP: assert property (@(posedge clock) disable iff (!rst_b)
      stop_cond |=> sda_oe_b ##1 sda_oe_b)
      else $error("line held after stop");
   // a start or stop in the same cycle wins, so those cycles are left out below
   AST_START_RESYNC: assert property (@(posedge clock) disable iff (!rst_b)
      start_cond |=> state_q == FCR_ST_ADDR && cnt_q == 4'h0 && sda_oe_b)
      else $error("start did not restart the address phase");
   AST_PTR_ACK: assert property (@(posedge clock) disable iff (!rst_b)
      state_q == FCR_ST_PTR && scl_fall && byte_full && !start_cond && !stop_cond
      |=> !sda_oe_b && ptr_q == $past(shift_q))
      else $error("pointer byte not taken or not acknowledged");
   AST_DATA_ACK: assert property (@(posedge clock) disable iff (!rst_b)
      state_q == FCR_ST_WDATA && scl_fall && byte_full && !start_cond && !stop_cond
      |-> rif.wr_stb ##1 !sda_oe_b)
      else $error("data byte not written or not acknowledged");
   AST_READ_FIRST: assert property (@(posedge clock) disable iff (!rst_b)
      state_q == FCR_ST_ADDR_ACK && rw_q && scl_fall && !start_cond && !stop_cond
      |=> sda_oe_b == $past(rif.rdata[7]))
      else $error("first read bit does not match the register");
   AST_NACK_IDLE: assert property (@(posedge clock) disable iff (!rst_b)
      state_q == FCR_ST_RACK && scl_rise && !master_ack && !start_cond && !stop_cond
      |=> state_q == FCR_ST_IDLE && sda_oe_b)
      else $error("read went on after a not-acknowledge");

endmodule

// ---- fcr_host_model.sv ----
// serial master model standing in for the host controller
module fcr_host_model (
   // clock
   input wire logic clock,
   // serial pins, a released data line reads back high through the pull-up
   output logic scl,
   output logic sda_rel,
   input wire logic sda_line
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end

   // ---------------------------------------------------------------
   // bus phases
   // ---------------------------------------------------------------
   // four clocks a phase keeps well above the slave's sampling need
   task automatic q();
      repeat (4) @(posedge clock);
      #1;
   endtask

   // also serves as repeated start, since it releases data first
   task automatic start();
      sda_rel = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_rel = 1'b0;
      q();
      scl = 1'b0;
      q();
   endtask

   task automatic stop();
      sda_rel = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_rel = 1'b1;
      q();
   endtask

   // data held over the whole high phase, read back at its end just before the fall
   task automatic bit_io(input logic b, output logic r);
      sda_rel = b;
      q();
      scl = 1'b1;
      q();
      r = sda_line;
      scl = 1'b0;
      q();
   endtask

   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   task automatic get_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(nack, r);
   endtask
endmodule

// ---- fault_flag_and_mask_regs_test.sv ----
// self-checking bench for the fault flag and mask registers
`include "fcr_defs.svh"

module fault_flag_and_mask_regs_test import fcr_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic scl, sda_rel, sda_line, sda_out, sda_oe_b, int_b, thermistor_sense_enable;
   logic [3:0] flt = 4'h0;
   logic [3:0] src = 4'h0;
   fcr_ts_code_t code = FCR_TS_NORMAL;
   logic [7:0] sup [4] = '{8'h8C, 8'h8A, 8'h89, 8'h80};
   logic [7:0] m8, flag, keep8;
   logic a;
   int fails = 0;
   int cmp_count = 0;

   always #2 clock = ~clock;
   // open-drain wire: low when either party pulls it
   assign sda_line = sda_rel & (sda_oe_b | sda_out);

   fcr_top i_fcr_top (.clock(clock), .rst_b(rst_b), .scl(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_b(sda_oe_b), .input_overvoltage_det(flt[3]),
      .input_below_sleep(flt[2]), .battery_low_lockout_det(flt[1]),
      .battery_overcurrent_evt(flt[0]), .thermistor_fault_code_in(code),
      .pushbutton_wake_pend(src[3]), .pushbutton_reset_pend(src[2]),
      .safety_timer_fault(src[1]), .charge_status_pend(src[0]), .int_b(int_b),
      .thermistor_sense_enable(thermistor_sense_enable));

   fcr_host_model i_fcr_host_model (.clock(clock), .scl(scl), .sda_rel(sda_rel),
      .sda_line(sda_line));

   // ---------------------------------------------------------------
   // checks and access tasks
   // ---------------------------------------------------------------
   task automatic chk1(input logic got, input logic exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d);
      logic a0, a1, a2;
      i_fcr_host_model.start();
      i_fcr_host_model.put_byte({`FCR_SLAVE_ADDR, 1'b0}, a0);
      i_fcr_host_model.put_byte(ofs, a1);
      i_fcr_host_model.put_byte(d, a2);
      i_fcr_host_model.stop();
      chk1(a0 & a1 & a2, 1'b1, "write acknowledge");
   endtask

   task automatic reg_rd(input logic [7:0] ofs, input logic [7:0] exp);
      logic a0, a1, a2;
      logic [7:0] d;
      i_fcr_host_model.start();
      i_fcr_host_model.put_byte({`FCR_SLAVE_ADDR, 1'b0}, a0);
      i_fcr_host_model.put_byte(ofs, a1);
      i_fcr_host_model.start();
      i_fcr_host_model.put_byte({`FCR_SLAVE_ADDR, 1'b1}, a2);
      i_fcr_host_model.get_byte(1'b1, d);
      i_fcr_host_model.stop();
      chk1(a0 & a1 & a2, 1'b1, "read acknowledge");
      chk8(d, exp, "read data");
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      tick(16);
      rst_b = 1'b1;
      tick(2);
      chk1(int_b, 1'b1, "idle interrupt");
      chk1(thermistor_sense_enable, 1'b1, "sense enable reset");
      reg_rd(`FCR_OFS_FAULT, 8'h00);
      reg_rd(`FCR_OFS_TEMP, 8'h88);
      $display("test reset values done");
      for (int c = 0; c < 4; c++) begin
         code = fcr_ts_code_t'(c);
         tick(2);
         reg_rd(`FCR_OFS_TEMP, {1'b1, 2'(c), 5'h08});
      end
      // read-only code and reserved bit must ignore the written ones
      reg_wr(`FCR_OFS_TEMP, 8'h7F);
      reg_rd(`FCR_OFS_TEMP, 8'h6F);
      chk1(thermistor_sense_enable, 1'b0, "sense disabled");
      reg_wr(`FCR_OFS_TEMP, 8'h88);
      reg_rd(8'h00, `FCR_UNMAPPED_DATA);
      reg_rd(8'h03, `FCR_UNMAPPED_DATA);
      i_fcr_host_model.start();
      i_fcr_host_model.put_byte({`FCR_SLAVE_ADDR ^ 7'h01, 1'b0}, a);
      i_fcr_host_model.stop();
      chk1(a, 1'b0, "foreign address");
      $display("test temperature register and addressing done");
      for (int m = 0; m < 2; m++) begin
         for (int i = 0; i < 4; i++) begin
            m8 = (m == 1) ? (8'h08 >> i) : 8'h00;
            flag = 8'h80 >> i;
            keep8 = ((i == 0) || (i == 2)) ? flag : 8'h00;
            reg_wr(`FCR_OFS_FAULT, m8);
            flt[3 - i] = 1'b1;
            // overcurrent is an event: one high cycle only
            if (i == 3) begin
               tick(1);
               flt[0] = 1'b0;
            end
            tick(3);
            chk1(int_b, m == 1, "fault interrupt");
            reg_rd(`FCR_OFS_FAULT, flag | m8);
            reg_rd(`FCR_OFS_FAULT, keep8 | m8);
            flt[3 - i] = 1'b0;
            tick(3);
            reg_rd(`FCR_OFS_FAULT, keep8 | m8);
            reg_rd(`FCR_OFS_FAULT, m8);
            chk1(int_b, 1'b1, "fault interrupt cleared");
         end
      end
      // flag bits are read-only: written ones must not show
      reg_wr(`FCR_OFS_FAULT, 8'hF0);
      reg_rd(`FCR_OFS_FAULT, 8'h00);
      $display("test fault flags and masks done");
      for (int j = 0; j < 4; j++) begin
         src[3 - j] = 1'b1;
         tick(3);
         chk1(int_b, 1'b0, "source interrupt");
         reg_wr(`FCR_OFS_TEMP, sup[j]);
         tick(3);
         chk1(int_b, 1'b1, "source suppressed");
         reg_wr(`FCR_OFS_TEMP, 8'h88);
         src[3 - j] = 1'b0;
      end
      $display("test interrupt source masks done");
      results();
   end

   // the tests need roughly a third of this span
   initial begin
      #300us;
      fails++;
      $display("unexpected at %0t: watchdog expired", $time);
      results();
   end
endmodule
